// ===== logic/i2ctc_params.svh
// Register offsets, field positions and reset values of the transfer control block
`ifndef I2CTC_PARAMS_SVH
`define I2CTC_PARAMS_SVH
`define I2CTC_OFS_IEN 8'h00
`define I2CTC_OFS_XCTL 8'h04
`define I2CTC_OFS_STAT 8'h18
`define I2CTC_OFS_SCLR 8'h1C
`define I2CTC_OFS_CONF 8'h20
`define I2CTC_IEN_RST 32'h0000_0000
`define I2CTC_IEN_WMASK 32'h0000_00FF
`define I2CTC_XCTL_RST 32'h0000_0000
`define I2CTC_XCTL_WMASK 32'h07FF_FFFF
`define I2CTC_CONF_RST 32'h0000_0000
`define I2CTC_CONF_WMASK 32'h0000_0003
`define I2CTC_B_EN 0
`define I2CTC_B_TXIE 1
`define I2CTC_B_RXIE 2
`define I2CTC_B_ADDIE 3
`define I2CTC_B_NAKIE 4
`define I2CTC_B_STPIE 5
`define I2CTC_B_DIR 10
`define I2CTC_B_WIDE 11
`define I2CTC_B_START 13
`define I2CTC_B_STOP 14
`define I2CTC_B_NAKOV 15
`define I2CTC_B_CNT 16
`define I2CTC_B_RELOAD 24
`define I2CTC_B_AUTO 25
`define I2CTC_B_CHK 26
`define I2CTC_S_TXF 0
`define I2CTC_S_RXF 2
`define I2CTC_S_ADDF 3
`define I2CTC_S_NAKF 4
`define I2CTC_S_STPF 5
`define I2CTC_S_XDONE 6
`define I2CTC_S_RDONE 7
`define I2CTC_C_SBC 0
`define I2CTC_C_SSOFF 1
`endif

// ===== logic/i2ctc_pkg.sv
// Types shared by the transfer control block and its surroundings
package i2ctc_pkg;
  // One-cycle events reported by the serial engine
  typedef struct packed {
    logic addr_sent;
    logic arb_lost;
    logic timeout;
    logic byte_done;
    logic nak_rx;
    logic nak_sent;
    logic check_sent;
    logic addr_matched;
  } i2ctc_ev_s;
  // Levels reported by the serial engine
  typedef struct packed {
    logic master_mode;
    logic tx_request;
    logic rx_not_empty;
    logic over_under_error;
    logic check_en;
    logic check_nak;
  } i2ctc_st_s;
  // Byte counter states, Gray along idle, run, hold
  typedef enum logic [1:0] {
    I2CTC_CNT_IDLE = 2'b00,
    I2CTC_CNT_RUN = 2'b01,
    I2CTC_CNT_HOLD = 2'b11
  } i2ctc_cnt_e;
endpackage

// ===== logic/i2ctc_top.sv
// Transfer control of a two-wire bus peripheral: control registers, byte counter, request bits
//
// Contract
// - stop seen flag raises interrupt when enabled
// - received not-acknowledge raises interrupt when enabled
// - slave address match raises interrupt when enabled
// - receive buffer not empty raises interrupt
// - transmit request interrupt; bit 0 enables peripheral
// - check byte request cleared by hardware events
// - check byte request ignored in reload mode
// - count done: done flag, or automatic stop
// - automatic finish only without reload, software owned
// - reload mode reloads count, sets reload flag
// - eight-bit byte count; slave needs byte control
// - slave acknowledges unless override forces not-acknowledge
// - override cleared by hardware events
// - check handling or stretch-off error decide acknowledge
// - stop request cleared on stop or disable
// - start request cleared after address sent
// - start also cleared on loss, timeout, disable, clear
// - direction bit selects receive, locked while starting
// - wide address bit locked while starting
//
// The implementer's own choice: the Wishbone register port.
`timescale 1ns/100ps
`include "i2ctc_params.svh"
module i2ctc_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Serial engine
  input wire i2ctc_pkg::i2ctc_ev_s ev_i,
  input wire i2ctc_pkg::i2ctc_st_s st_i,
  // Bus pins, sampled only
  input wire logic scl_i,
  input wire logic sda_i,
  // Control toward the serial engine
  output logic irq_o,
  output logic start_req_o,
  output logic stop_req_o,
  output logic nak_o,
  output logic check_send_o,
  output logic master_rx_o,
  output logic wide_addr_o,
  output logic [7:0] bytes_left_o
);

  logic [31:0] ien;
  logic [31:0] xctl;
  logic [31:0] conf;
  logic [7:0] stat_flags;
  logic [7:3] stat_sticky;
  logic [7:0] cnt;
  logic auto_stop;
  i2ctc_pkg::i2ctc_cnt_e cnt_state;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic scl_f;
  logic sda_f;
  logic stop_det;
  logic en;
  logic wr;
  logic [31:0] wmask;
  logic [31:0] next_xctl;
  logic clr_chk;
  logic clr_nakov;
  logic clr_stop;
  logic clr_start;
  logic slave_cnt_ok;
  logic count_end;
  logic next_irq;

  // Byte lanes to bit mask, used by every writable register
  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  // Merge of written bits into a register under lane and writable masks
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [31:0] m);
    merge = (old & ~m) | (d & m);
  endfunction

  assign en = ien[`I2CTC_B_EN];
  assign wr = cyc_i && stb_i && we_i && !ack_o;
  assign wmask = lane_mask(sel_i);

  // Wishbone answer one cycle after the request; ack falls the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // Read mux; unmapped offsets read zero and still acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (cyc_i && stb_i && !we_i && !ack_o) begin
      case (adr_i)
        `I2CTC_OFS_IEN: dat_o <= ien;
        `I2CTC_OFS_XCTL: dat_o <= xctl;
        `I2CTC_OFS_STAT: dat_o <= {8'h00, cnt, 8'h00, stat_flags};
        `I2CTC_OFS_CONF: dat_o <= conf;
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Interrupt enables and peripheral enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien <= `I2CTC_IEN_RST;
    end else if (wr && adr_i == `I2CTC_OFS_IEN) begin
      ien <= merge(ien, dat_i, wmask & `I2CTC_IEN_WMASK);
    end
  end

  // Slave byte control and stretch disable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conf <= `I2CTC_CONF_RST;
    end else if (wr && adr_i == `I2CTC_OFS_CONF) begin
      conf <= merge(conf, dat_i, wmask & `I2CTC_CONF_WMASK);
    end
  end

  // Pin sampling: the first stage feeds only the second; a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      if (scl_sync[1] == scl_sync[2]) begin
        scl_f <= scl_sync[2];
      end
      if (sda_sync[1] == sda_sync[2]) begin
        sda_f <= sda_sync[2];
      end
    end
  end

  // Stop condition: data rises while clock stays high
  assign stop_det = en && scl_f && !sda_f && (sda_sync[1] == sda_sync[2]) && sda_sync[2];

  // Hardware clear conditions for the request bits
  assign clr_chk = ev_i.check_sent || ev_i.addr_matched || stop_det || !en;
  assign clr_nakov = ev_i.nak_sent || stop_det || ev_i.addr_matched || !en;
  assign clr_stop = stop_det || !en;
  assign clr_start = ev_i.addr_sent || ev_i.arb_lost || ev_i.timeout || !en
                     || (wr && adr_i == `I2CTC_OFS_SCLR && sel_i[0] && dat_i[`I2CTC_S_ADDF]);

  // Software write of the transfer control word; direction and width held while starting
  always_comb begin
    next_xctl = xctl;
    if (wr && adr_i == `I2CTC_OFS_XCTL) begin
      next_xctl = merge(xctl, dat_i, wmask & `I2CTC_XCTL_WMASK);
      if (xctl[`I2CTC_B_START]) begin
        next_xctl[`I2CTC_B_DIR] = xctl[`I2CTC_B_DIR];
        next_xctl[`I2CTC_B_WIDE] = xctl[`I2CTC_B_WIDE];
      end
    end
  end

  // Request bits: a hardware clear overrides a simultaneous software set; disabled reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xctl <= `I2CTC_XCTL_RST;
    end else begin
      xctl <= next_xctl;
      if (clr_chk) begin
        xctl[`I2CTC_B_CHK] <= 1'b0;
      end
      if (clr_nakov) begin
        xctl[`I2CTC_B_NAKOV] <= 1'b0;
      end
      if (clr_stop) begin
        xctl[`I2CTC_B_STOP] <= 1'b0;
      end
      if (clr_start) begin
        xctl[`I2CTC_B_START] <= 1'b0;
      end
    end
  end

  // Count only counts in master mode, or in slave mode with byte control
  assign slave_cnt_ok = st_i.master_mode || conf[`I2CTC_C_SBC];
  assign count_end = cnt_state == i2ctc_pkg::I2CTC_CNT_RUN && ev_i.byte_done && cnt == 8'h01;

  // Byte counter; in hold a fresh write of the count resumes the transfer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_state <= i2ctc_pkg::I2CTC_CNT_IDLE;
      cnt <= 8'h00;
    end else if (!en || stop_det) begin
      cnt_state <= i2ctc_pkg::I2CTC_CNT_IDLE;
      cnt <= 8'h00;
    end else begin
      case (cnt_state)
        i2ctc_pkg::I2CTC_CNT_IDLE: begin
          if ((ev_i.addr_sent || ev_i.addr_matched) && slave_cnt_ok) begin
            cnt <= xctl[`I2CTC_B_CNT +: 8];
            cnt_state <= i2ctc_pkg::I2CTC_CNT_RUN;
          end
        end
        i2ctc_pkg::I2CTC_CNT_RUN: begin
          if (ev_i.byte_done && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
          end
          if (count_end) begin
            cnt_state <= xctl[`I2CTC_B_RELOAD] ? i2ctc_pkg::I2CTC_CNT_HOLD
                                               : i2ctc_pkg::I2CTC_CNT_IDLE;
          end
        end
        i2ctc_pkg::I2CTC_CNT_HOLD: begin
          if (wr && adr_i == `I2CTC_OFS_XCTL && sel_i[2]) begin
            cnt <= dat_i[`I2CTC_B_CNT +: 8];
            cnt_state <= i2ctc_pkg::I2CTC_CNT_RUN;
          end
        end
        default: begin
          cnt_state <= i2ctc_pkg::I2CTC_CNT_IDLE;
        end
      endcase
    end
  end

  // Automatic stop after the last byte; cleared by the stop it causes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      auto_stop <= 1'b0;
    end else if (clr_stop) begin
      auto_stop <= 1'b0;
    end else if (count_end && st_i.master_mode && !xctl[`I2CTC_B_RELOAD] && xctl[`I2CTC_B_AUTO]) begin
      auto_stop <= 1'b1;
    end
  end

  // Sticky flags; an event in the clearing cycle wins over the clear
  always_ff @(posedge clk_i) begin
    if (rst_i || !en) begin
      stat_sticky <= 5'h00;
    end else begin
      if (wr && adr_i == `I2CTC_OFS_SCLR && sel_i[0]) begin
        stat_sticky <= stat_sticky & ~dat_i[7:3];
      end
      if (ev_i.addr_matched && !st_i.master_mode) begin
        stat_sticky[`I2CTC_S_ADDF] <= 1'b1;
      end
      if (ev_i.nak_rx) begin
        stat_sticky[`I2CTC_S_NAKF] <= 1'b1;
      end
      if (stop_det) begin
        stat_sticky[`I2CTC_S_STPF] <= 1'b1;
      end
      if (count_end && st_i.master_mode && !xctl[`I2CTC_B_RELOAD] && !xctl[`I2CTC_B_AUTO]) begin
        stat_sticky[`I2CTC_S_XDONE] <= 1'b1;
      end
      if (count_end && xctl[`I2CTC_B_RELOAD]) begin
        stat_sticky[`I2CTC_S_RDONE] <= 1'b1;
      end
    end
  end

  // Level flags follow the engine directly; kept apart from the sticky register so each bit has one driver
  assign stat_flags = {stat_sticky, st_i.rx_not_empty, 1'b0, st_i.tx_request};

  // Interrupt request: each enabled source, gated by the peripheral enable
  always_comb begin
    next_irq = en && (
      (ien[`I2CTC_B_STPIE] && stat_flags[`I2CTC_S_STPF]) ||
      (ien[`I2CTC_B_NAKIE] && stat_flags[`I2CTC_S_NAKF]) ||
      (ien[`I2CTC_B_ADDIE] && stat_flags[`I2CTC_S_ADDF]) ||
      (ien[`I2CTC_B_RXIE] && stat_flags[`I2CTC_S_RXF]) ||
      (ien[`I2CTC_B_TXIE] && stat_flags[`I2CTC_S_TXF]));
  end

  // Registered so the line never glitches on a flag update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= next_irq;
    end
  end

  // Acknowledge decision: check handling first, then the stretch-off error, then the override
  always_comb begin
    if (st_i.check_en) begin
      nak_o = st_i.check_nak;
    end else if (conf[`I2CTC_C_SSOFF] && st_i.over_under_error) begin
      nak_o = 1'b1;
    end else begin
      nak_o = !st_i.master_mode && xctl[`I2CTC_B_NAKOV];
    end
  end

  // Request levels toward the engine
  assign start_req_o = xctl[`I2CTC_B_START];
  assign stop_req_o = xctl[`I2CTC_B_STOP] || auto_stop;
  assign check_send_o = xctl[`I2CTC_B_CHK] && !xctl[`I2CTC_B_RELOAD] && slave_cnt_ok;
  assign master_rx_o = xctl[`I2CTC_B_DIR];
  assign wide_addr_o = xctl[`I2CTC_B_WIDE];
  assign bytes_left_o = cnt;

  a_irq_stop_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && ien[`I2CTC_B_STPIE] && stat_flags[`I2CTC_S_STPF]) |=> irq_o)
    else $error("stop interrupt missing");

  a_irq_has_cause: assert property (@(posedge clk_i) disable iff (rst_i)
    irq_o |-> $past(next_irq))
    else $error("interrupt without enabled source");

  a_chk_hw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i.addr_matched || stop_det) |=> !xctl[`I2CTC_B_CHK])
    else $error("check request not cleared");

  a_chk_reload_mute: assert property (@(posedge clk_i) disable iff (rst_i)
    xctl[`I2CTC_B_RELOAD] |-> !check_send_o)
    else $error("check request active in reload");

  a_reload_flag_set: assert property (@(posedge clk_i) disable iff (rst_i || !en)
    (count_end && xctl[`I2CTC_B_RELOAD] && !stop_det) |=> stat_flags[`I2CTC_S_RDONE]
      ##0 cnt_state == i2ctc_pkg::I2CTC_CNT_HOLD)
    else $error("reload flag or hold missing");

  a_nak_forced: assert property (@(posedge clk_i) disable iff (rst_i)
    (!st_i.check_en && conf[`I2CTC_C_SSOFF] && st_i.over_under_error) |-> nak_o)
    else $error("forced not-acknowledge missing");

  a_start_hw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i.addr_sent || ev_i.arb_lost || ev_i.timeout) |=> !start_req_o)
    else $error("start request not cleared");

  a_disable_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    !en |=> (xctl[`I2CTC_B_START] || xctl[`I2CTC_B_STOP] || xctl[`I2CTC_B_NAKOV] || xctl[`I2CTC_B_CHK]) == 1'b0)
    else $error("request bit survives disable");

  a_dir_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    xctl[`I2CTC_B_START] |=> xctl[11:10] == $past(xctl[11:10]))
    else $error("direction or width changed while starting");

  a_nakov_hw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    (ev_i.nak_sent || ev_i.addr_matched || stop_det) |=> !xctl[`I2CTC_B_NAKOV])
    else $error("acknowledge override not cleared");

  a_stop_hw_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    stop_det |=> !stop_req_o)
    else $error("stop request survives stop");

  a_rx_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && ien[`I2CTC_B_RXIE] && st_i.rx_not_empty) |=> irq_o)
    else $error("receive interrupt missing");

  a_addr_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && ev_i.addr_matched && !st_i.master_mode) |=> stat_flags[`I2CTC_S_ADDF])
    else $error("address match flag missing");

  a_done_flag_set: assert property (@(posedge clk_i) disable iff (rst_i)
    (en && count_end && st_i.master_mode && !xctl[`I2CTC_B_RELOAD] && !xctl[`I2CTC_B_AUTO])
      |=> stat_flags[`I2CTC_S_XDONE])
    else $error("transfer done flag missing");

endmodule // i2ctc_top

// ===== verification/i2ctc_peer.sv
// Model of the serial engine and of the bus wires facing the transfer control block
`timescale 1ns/100ps
module i2ctc_peer (
  // Clock
  input wire logic clk_i,
  // Engine side
  output i2ctc_pkg::i2ctc_ev_s ev_o,
  output i2ctc_pkg::i2ctc_st_s st_o,
  // Bus wires
  output logic scl_o,
  output logic sda_o
);
  // Wires idle high through the pull-ups; the link clock stands still between frames
  initial begin
    ev_o = '0;
    st_o = '0;
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  // One-cycle event pulse, launched just after an edge
  task automatic fire(input i2ctc_pkg::i2ctc_ev_s e);
    @(posedge clk_i);
    ev_o <= e;
    @(posedge clk_i);
    ev_o <= '0;
  endtask
  // Engine levels change just after an edge
  task automatic set_st(input i2ctc_pkg::i2ctc_st_s s);
    @(posedge clk_i);
    st_o <= s;
  endtask
  // Half a link clock period, 80 ns
  task automatic half();
    repeat (8) @(posedge clk_i);
  endtask
  // Frame end: data rises while the link clock is high
  task automatic stop_cond();
    scl_o <= 1'b0;
    half();
    sda_o <= 1'b0;
    half();
    scl_o <= 1'b1;
    half();
    sda_o <= 1'b1;
    half();
  endtask
endmodule // i2ctc_peer

// ===== verification/i2ctc_top_tb.sv
// Self-checking bench of the transfer control block
`timescale 1ns/100ps
`include "i2ctc_params.svh"
module i2ctc_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic we = 1'b0;
  logic [3:0] sel = 4'h0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic [31:0] rd;
  logic ack, irq, start, stop, nak, chks, mrx, wide;
  logic [7:0] left;
  i2ctc_pkg::i2ctc_ev_s ev;
  i2ctc_pkg::i2ctc_st_s st;
  logic scl, sda;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] q;
  logic [3:0] wsel = 4'hF;
  logic [7:0] iv;
  logic [7:0] evs [4] = '{8'h00, 8'h00, 8'h01, 8'h08};
  logic [5:0] sts [4] = '{6'h10, 6'h08, 6'h00, 6'h00};
  logic [7:0] ens [4] = '{8'h02, 8'h04, 8'h08, 8'h10};
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  i2ctc_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat), .dat_o(rd), .we_i(we),
    .sel_i(sel), .cyc_i(cyc), .stb_i(stb), .ack_o(ack), .ev_i(ev), .st_i(st), .scl_i(scl),
    .sda_i(sda), .irq_o(irq), .start_req_o(start), .stop_req_o(stop), .nak_o(nak),
    .check_send_o(chks), .master_rx_o(mrx), .wide_addr_o(wide), .bytes_left_o(left));
  i2ctc_peer u_peer (.clk_i(clk_i), .ev_o(ev), .st_o(st), .scl_o(scl), .sda_o(sda));
  // Verdict and end of run, shared by the sequence and the watchdog
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Expected interrupt level from the enables, the engine levels and the events raised
  function automatic logic exp_irq(input logic [7:0] ie, input logic [5:0] sv, input logic [7:0] evv);
    exp_irq = ie[0] && ((ie[1] && sv[4]) || (ie[2] && sv[3])
      || (ie[3] && evv[0] && !sv[5]) || (ie[4] && evv[3]));
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
  endtask
  // Classic Wishbone cycle; read data taken at the edge that samples ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= wsel;
    // Waits for the answer however long it takes; only the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Master transfer of a random count, optionally ending by itself
  task automatic xfer(input logic au);
    logic [7:0] n;
    logic d;
    logic w;
    logic [31:0] v;
    n = 8'($urandom_range(8, 1));
    d = 1'($urandom_range(1, 0));
    w = 1'($urandom_range(1, 0));
    v = {5'h00, 1'b0, au, 1'b0, n, 2'b00, 1'b1, 1'b0, w, d, 10'h000};
    wb(1, `I2CTC_OFS_XCTL, v);
    tick(1);
    chk("start", 1, start);
    chk("dir", d, mrx);
    chk("wide", w, wide);
    wb(1, `I2CTC_OFS_XCTL, v ^ 32'h0000_0C00);
    wb(0, `I2CTC_OFS_XCTL, 0);
    chk("dir locked", v[11:10], q[11:10]);
    u_peer.fire(8'h80);
    tick(2);
    chk("start after addr", 0, start);
    chk("count", n, left);
    repeat (n) u_peer.fire(8'h10);
    tick(2);
    chk("left", 0, left);
    if (au) begin
      chk("auto stop", 1, stop);
      u_peer.stop_cond();
      tick(6);
      chk("stop cleared", 0, stop);
      chk("stop irq", 1, irq);
    end else begin
      wb(0, `I2CTC_OFS_STAT, 0);
      chk("done flag", 1, q[6]);
      chk("no stop", 0, stop);
    end
    wb(1, `I2CTC_OFS_SCLR, 32'h0000_00F8);
  endtask
  // Hang guard, far beyond the length of the sequence
  initial begin
    tick(20000);
    n_mismatch++;
    give_verdict();
  end
  // Main sequence
  initial begin
    void'($urandom(32'h8ef64c19));
    tick(4);
    rst_i <= 1'b0;
    wb(0, `I2CTC_OFS_IEN, 0);
    chk("ien reset", `I2CTC_IEN_RST, q);
    wb(0, `I2CTC_OFS_XCTL, 0);
    chk("xctl reset", `I2CTC_XCTL_RST, q);
    wb(1, 8'hC3, 32'hFFFF_FFFF);
    wb(0, 8'hC3, 0);
    chk("unmapped", 0, q);
    wb(1, `I2CTC_OFS_IEN, 32'h0000_003F);
    wb(0, `I2CTC_OFS_IEN, 0);
    chk("ien", 32'h0000_003F, q);
    u_peer.set_st(6'h20);
    for (int i = 0; i < 4; i++) xfer(1'(i % 2));
    // Reload keeps the transfer open and masks the check byte request
    wb(1, `I2CTC_OFS_XCTL, 32'h0502_2000);
    tick(1);
    chk("check masked", 0, chks);
    u_peer.fire(8'h80);
    repeat (2) u_peer.fire(8'h10);
    tick(2);
    wb(0, `I2CTC_OFS_STAT, 0);
    chk("reload flag", 1, q[7]);
    wsel = 4'h4;
    wb(1, `I2CTC_OFS_XCTL, 32'h0503_0000);
    wsel = 4'hF;
    tick(2);
    chk("reloaded", 3, left);
    u_peer.stop_cond();
    tick(6);
    wb(0, `I2CTC_OFS_XCTL, 0);
    chk("check cleared", 0, q[26]);
    // Check byte request seen in master mode, then dropped once the byte has gone
    wb(1, `I2CTC_OFS_XCTL, 32'h0400_0000);
    tick(1);
    chk("check send", 1, chks);
    u_peer.fire(8'h02);
    tick(2);
    chk("check byte clear", 0, chks);
    // Start request dropped by loss, timeout and the match clear
    for (int i = 0; i < 3; i++) begin
      wb(1, `I2CTC_OFS_XCTL, 32'h0000_2000);
      if (i < 2) begin
        u_peer.fire(i == 0 ? 8'h40 : 8'h20);
      end else begin
        wsel = 4'h1;
        wb(1, `I2CTC_OFS_SCLR, 32'h0000_0008);
        wsel = 4'hF;
      end
      tick(2);
      chk("start dropped", 0, start);
    end
    // Slave acknowledge override and what overrules it
    u_peer.set_st(6'h00);
    tick(1);
    chk("ack", 0, nak);
    wb(1, `I2CTC_OFS_XCTL, 32'h0000_8000);
    tick(1);
    chk("nak forced", 1, nak);
    u_peer.fire(8'h04);
    tick(2);
    chk("nak sent", 0, nak);
    wb(1, `I2CTC_OFS_XCTL, 32'h0000_8000);
    u_peer.set_st(6'h02);
    tick(1);
    chk("check decides", 0, nak);
    u_peer.set_st(6'h03);
    tick(1);
    chk("check nak", 1, nak);
    wb(1, `I2CTC_OFS_XCTL, 0);
    wb(1, `I2CTC_OFS_CONF, 32'h0000_0002);
    u_peer.set_st(6'h04);
    tick(1);
    chk("error nak", 1, nak);
    wb(1, `I2CTC_OFS_CONF, 0);
    // Transmit, receive, address and not-acknowledge sources each enabled, then masked
    for (int i = 0; i < 8; i++) begin
      u_peer.set_st(6'h00);
      wb(1, `I2CTC_OFS_SCLR, 32'h0000_00F8);
      iv = (i < 4) ? (ens[i % 4] | 8'h01) : ((8'($urandom) & ~ens[i % 4]) | 8'h01);
      wb(1, `I2CTC_OFS_IEN, {24'h0, iv});
      u_peer.set_st(sts[i % 4]);
      if (evs[i % 4] != 8'h00) u_peer.fire(evs[i % 4]);
      tick(3);
      chk("irq", exp_irq(iv, sts[i % 4], evs[i % 4]), irq);
    end
    // Disable clears every request bit
    wb(1, `I2CTC_OFS_XCTL, 32'h0400_E000);
    wb(1, `I2CTC_OFS_IEN, 0);
    wb(0, `I2CTC_OFS_XCTL, 0);
    chk("disabled", 0, q & 32'h0400_E000);
    give_verdict();
  end
endmodule // i2ctc_top_tb
